// *** src/pbh_consts.svh ***
// constants for the pushbutton power handshake block
`ifndef PBH_CONSTS_SVH
`define PBH_CONSTS_SVH

// debounce window: 10 ms at 50 ns per cycle
`define PBH_DEB_TIME_US    10000
`define PBH_CLK_PERIOD_NS  50
`define PBH_DEB_CYCLES     ((`PBH_DEB_TIME_US * 1000) / `PBH_CLK_PERIOD_NS)
`define PBH_DEB_CNT_W      18
`define PBH_DEB_CNT_ZERO   18'h00000
`define PBH_DEB_CNT_ONE    18'h00001
`define PBH_DEB_LAST_OFS   1
`define PBH_BTN_IDLE       1'h0
`define PBH_FLAG_CLR       1'h0

`endif

// *** src/pbh_pkg.sv ***
// types for the pushbutton power handshake block
`include "pbh_consts.svh"
package pbh_pkg;
    typedef enum logic [1:0] {
        PBH_OFF,
        PBH_ON,
        PBH_REQ
    } pbh_state_e;

    typedef logic [`PBH_DEB_CNT_W-1:0] pbh_cnt_t;

    typedef struct packed {
        logic power_on;
        logic off_req;
    } pbh_status_s;
endpackage : pbh_pkg

// *** src/pbh_power_handshake.sv ***
// pushbutton power sequencer with host shutdown handshake
// Summary of operation
// - After reset the block sits in off until a filtered button press.
// - In off, a filtered press turns power on.
// - In on, a filtered press raises the shutdown request, not power off.
// - With the request raised, power stays on until acknowledge is high.
// - Bounce during one press yields exactly one press event.
// - An undriven acknowledge follows the request, so shutdown needs no host.
`timescale 1ns/1ps
`default_nettype none
`include "pbh_consts.svh"
module pbh_power_handshake #(
    parameter int DEB_CYCLES = `PBH_DEB_CYCLES  // stable cycles to accept
) (
    input  wire logic          clock,       // 20 MHz system clock
    input  wire logic          resetn,      // async reset, active low
    input  wire logic          button,      // raw pushbutton, high = closed
    input  wire logic          ack_in,      // shutdown acknowledge level
    input  wire logic          ack_driven,  // high when host drives ack
    output var  pbh_pkg::pbh_status_s status // power_on and off_req, registered
);
    import pbh_pkg::*;

    // sequence state
    pbh_state_e state_r;
    pbh_state_e state_nxt;

    // button filter
    logic       btn_raw_r;
    logic       btn_stable_r;
    pbh_cnt_t   cnt_r;
    pbh_cnt_t   cnt_last;
    logic       differs;
    logic       settled;
    logic       press;

    // output flags, one flop each
    logic       power_on_r;
    logic       off_req_r;

    // acknowledge level as the sequencer sees it
    logic       ack_eff;

    // supply stays on while requesting, so the host can finish its work
    function automatic logic f_powered(
        input pbh_state_e st
    );
        logic result;
        case (st)
            PBH_ON: begin
                result = 1'h1;
            end
            PBH_REQ: begin
                result = 1'h1;
            end
            default: begin
                result = 1'h0;
            end
        endcase
        return result;
    endfunction : f_powered

    // request flag is high only in the request state
    function automatic logic f_requesting(
        input pbh_state_e st
    );
        logic result;
        case (st)
            PBH_REQ: begin
                result = 1'h1;
            end
            default: begin
                result = 1'h0;
            end
        endcase
        return result;
    endfunction : f_requesting

    // counter fixed at 18 bits: a window beyond its range would wrap
    function automatic pbh_cnt_t f_window_last(
        input int cycles
    );
        pbh_cnt_t result;
        result = pbh_cnt_t'(cycles - `PBH_DEB_LAST_OFS);
        return result;
    endfunction : f_window_last

    // true on the last sample of a full window away from the filtered level
    function automatic logic f_window_done(
        input logic     away,
        input pbh_cnt_t cnt,
        input pbh_cnt_t last
    );
        logic result;
        result = away && (cnt == last);
        return result;
    endfunction : f_window_done

    // acknowledge counts only while a request is pending
    function automatic logic f_ack_taken(
        input pbh_state_e st,
        input logic       ack
    );
        logic result;
        result = (st == PBH_REQ) && ack;
        return result;
    endfunction : f_ack_taken

    // input flop so the filter compares one clean sample per cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            btn_raw_r <= `PBH_BTN_IDLE;
        end else begin
            btn_raw_r <= button;
        end
    end

    // window bookkeeping
    assign cnt_last = f_window_last(DEB_CYCLES);
    assign differs  = (btn_raw_r != btn_stable_r);
    assign settled  = f_window_done(differs, cnt_r, cnt_last);

    // any sample back at the filtered level restarts the window
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= `PBH_DEB_CNT_ZERO;
        end else if (!differs) begin
            cnt_r <= `PBH_DEB_CNT_ZERO;
        end else if (settled) begin
            cnt_r <= `PBH_DEB_CNT_ZERO;
        end else begin
            cnt_r <= cnt_r + `PBH_DEB_CNT_ONE;
        end
    end

    // filtered level moves only after a full stable window
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            btn_stable_r <= `PBH_BTN_IDLE;
        end else if (settled) begin
            btn_stable_r <= btn_raw_r;
        end else begin
            btn_stable_r <= btn_stable_r;
        end
    end

    // one event per accepted closure; an accepted release gives none
    assign press = settled && btn_raw_r;

    // models the internal pull between request and acknowledge pins
    assign ack_eff = ack_driven ? ack_in : off_req_r;

    // next state of the power sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PBH_OFF: begin
                // a filtered release is no event and leaves power off
                if (press) begin
                    state_nxt = PBH_ON;
                end else begin
                    state_nxt = PBH_OFF;
                end
            end
            PBH_ON: begin
                // a press here never cuts power by itself
                if (press) begin
                    state_nxt = PBH_REQ;
                end else begin
                    state_nxt = PBH_ON;
                end
            end
            PBH_REQ: begin
                // presses are ignored; the host may take as long as it needs
                if (f_ack_taken(state_r, ack_eff)) begin
                    state_nxt = PBH_OFF;
                end else begin
                    state_nxt = PBH_REQ;
                end
            end
            default: begin
                // an illegal code falls back to the safe off state
                state_nxt = PBH_OFF;
            end
        endcase
    end

    // off is the power-up state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= PBH_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // flags from the next state so they line up with state_r
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            power_on_r <= `PBH_FLAG_CLR;
        end else begin
            power_on_r <= f_powered(state_nxt);
        end
    end

    // request flag; also feeds the open-pin acknowledge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            off_req_r <= `PBH_FLAG_CLR;
        end else begin
            off_req_r <= f_requesting(state_nxt);
        end
    end

    // both flags leave straight from their flops
    assign status = '{
        power_on: power_on_r,
        off_req:  off_req_r
    };
endmodule : pbh_power_handshake
`default_nettype wire

// *** sim/pbh_props.sv ***
// assertions for the pushbutton power handshake block
`timescale 1ns/1ps
`default_nettype none
module pbh_props #(
    parameter int DEB_CYCLES = 4  // stable cycles to accept
) (
    input wire logic                 clock,      // system clock
    input wire logic                 resetn,     // async reset, active low
    input wire logic                 button,     // raw pushbutton
    input wire logic                 ack_in,     // shutdown acknowledge
    input wire logic                 ack_driven, // high when host drives ack
    input wire pbh_pkg::pbh_status_s status      // power_on and off_req
);
    wire p = status.power_on;
    wire q = status.off_req;
    // open ack pin is pulled to the request level
    wire ae = ack_driven ? ack_in : q;
    // run of consecutive closed samples, saturating at the window
    int unsigned run_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            run_r <= 32'h0;
        end else if (!button) begin
            run_r <= 32'h0;
        end else if (run_r < DEB_CYCLES) begin
            run_r <= run_r + 32'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_on_edge;
        $rose(p);
    endsequence
    sequence s_ack_wait;
        q && !ae;
    endsequence
    sequence s_ack_seen;
        q && ae;
    endsequence
    property p_boot; $rose(resetn) |-> !p && !q; endproperty
    property p_on; s_on_edge |-> $past(button, DEB_CYCLES) && !q; endproperty
    property p_settle; s_on_edge |-> $past(run_r) >= DEB_CYCLES; endproperty
    property p_req; $rose(q) |-> p && $past(p); endproperty
    property p_hold; s_ack_wait |=> p && q; endproperty
    property p_off; s_ack_seen |=> !p && !q; endproperty
    property p_open; q && !ack_driven |=> !p; endproperty
    property p_one; s_on_edge |=> !q [*4]; endproperty
    a_boot: assert property (p_boot) else $error("on at reset");
    a_on: assert property (p_on) else $error("early on");
    a_settle: assert property (p_settle) else $error("short window");
    a_req: assert property (p_req) else $error("bad request");
    a_hold: assert property (p_hold) else $error("left early");
    a_off: assert property (p_off) else $error("no off");
    a_open: assert property (p_open) else $error("open ack");
    a_one: assert property (p_one) else $error("double press");
endmodule : pbh_props
bind pbh_power_handshake pbh_props #(
    .DEB_CYCLES(DEB_CYCLES)
) i_pbh_props (
    .clock      (clock),
    .resetn     (resetn),
    .button     (button),
    .ack_in     (ack_in),
    .ack_driven (ack_driven),
    .status     (status)
);
`default_nettype wire

// *** sim/pbh_host.sv ***
// host model answering the shutdown request after its own work
`timescale 1ns/1ps
`default_nettype none
module pbh_host (
    input  wire logic       clock, // system clock
    input  wire logic       req,   // shutdown request
    input  wire logic [3:0] lag,   // cycles of shutdown work
    output var  logic       ack    // shutdown acknowledge
);
    logic [3:0] cnt_r;
    always_ff @(posedge clock) begin
        cnt_r <= (req && cnt_r != 4'hF) ? cnt_r + 4'h1 : (req ? cnt_r : 4'h0);
        ack   <= req && cnt_r >= lag;
    end
endmodule : pbh_host
`default_nettype wire

// *** sim/pbh_power_handshake_bench.sv ***
// bench for the pushbutton power handshake block
`timescale 1ns/1ps
`default_nettype none
module pbh_power_handshake_bench;
    import pbh_pkg::*;
    logic clock = 0, resetn = 0, button = 0, ack_driven = 1, ack_in;
    pbh_status_s status;
    int miscompares = 0, check_count = 0;
    always #25 clock = ~clock;
    pbh_power_handshake #(
        .DEB_CYCLES(4)
    ) i_pbh_power_handshake (
        .clock      (clock),
        .resetn     (resetn),
        .button     (button),
        .ack_in     (ack_in),
        .ack_driven (ack_driven),
        .status     (status)
    );
    pbh_host i_pbh_host (.clock(clock), .req(status.off_req), .lag(4'h6),
                         .ack(ack_in));
    task automatic hold(input logic b, input int n);
        button = b;
        repeat (n) @(posedge clock);
        #1;
    endtask : hold
    task automatic chk(input logic [1:0] e);
        check_count++;
        if (status !== e) begin
            $display("Error %0t %h %h", $time, status, e);
            miscompares++;
        end
    endtask : chk
    // bursts shorter than the filter must be ignored
    task automatic t_boot;
        chk(2'h0);
        hold(1, 2); hold(0, 2); hold(1, 2); hold(0, 6);
        chk(2'h0);
    endtask : t_boot
    task automatic t_on;
        hold(1, 2); hold(0, 1); hold(1, 4);
        chk(2'h0);
        hold(1, 6);
        chk(2'h2);
        hold(0, 10);
        chk(2'h2);
    endtask : t_on
    task automatic t_req;
        hold(1, 6);
        chk(2'h3);
        hold(1, 3);
        chk(2'h3);
        hold(1, 7);
        chk(2'h0);
        hold(0, 10);
    endtask : t_req
    task automatic t_open;
        ack_driven = 0;
        hold(1, 10);
        chk(2'h2);
        hold(0, 10); hold(1, 5);
        chk(2'h3);
        hold(1, 5);
        chk(2'h0);
        hold(0, 10);
    endtask : t_open
    task automatic print_verdict;
        $display("miscompares %0d check_count %0d", miscompares, check_count);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (8) @(posedge clock);
        #1 resetn = 1;
        t_boot(); t_on(); t_req(); t_open();
        print_verdict();
    end
    initial begin
        #20000 miscompares++;
        print_verdict();
    end
endmodule : pbh_power_handshake_bench
`default_nettype wire
